// file: hw/apvs_pkg.sv
`default_nettype none
package apvs_pkg;
	// Field positions within the status word
	localparam int unsigned PEND_MSB = 17;
	localparam int unsigned PEND_LSB = 12;
	localparam int unsigned FLAG_BIT = 11;
	localparam int unsigned RSVD_MSB = 10;
	localparam int unsigned RSVD_LSB = 6;
	localparam int unsigned ACT_MSB = 5;
	localparam int unsigned ACT_LSB = 0;

	// Exception number encoding
	localparam logic [5:0] EXC_NONE = 6'h00;
	localparam logic [5:0] EXC_NMI = 6'h02;
	localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
	localparam logic [5:0] EXC_DEFERRED_SERVICE_CALL = 6'h0E;
	localparam logic [5:0] EXC_SYSTEM_TICK_TIMER = 6'h0F;
	localparam logic [5:0] EXC_FIRST_IRQ = 6'h10;
	localparam logic [5:0] EXC_LAST_IRQ = 6'h3B;
	localparam logic [5:0] EXC_RSVD_FIRST = 6'h3C;
	localparam int unsigned IRQ_BASE = 16;

	// Codes that name a real exception: 2..6, 11, 14..59
	localparam logic [63:0] LEGAL_MASK = 64'h0FFF_FFFF_FFFF_C87C;
	// Codes counted by the only-active flag: NMI and faults left out
	localparam logic [63:0] FLAG_MASK = 64'h0FFF_FFFF_FFFF_C800;

	// Reset values
	localparam logic [5:0] PEND_RESET = 6'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [4:0] RSVD_VALUE = 5'h00;
	localparam logic [5:0] ACT_RESET = 6'h00;

	// Fixed priorities sit above every configurable level
	localparam logic [3:0] PRIO_NMI = 4'h0;
	localparam logic [3:0] PRIO_HARD_FAULT = 4'h1;
	localparam logic [3:0] PRIO_OFFSET = 4'h2;
	localparam logic [3:0] PRIO_LOWEST = 4'hF;

	// Exception state handed over by the core
	typedef struct packed {
		logic [63:0] pending;
		logic [63:0] enabled;
		logic [63:0] active;
		logic [5:0] handler_number_field;
	} apvs_exc_state_t;

	// Read-only status word, bits 17:0
	typedef struct packed {
		logic [5:0] pending_exception_number;
		logic only_active_handler_flag;
		logic [4:0] reserved;
		logic [5:0] active_exception_number;
	} apvs_status_t;
endpackage : apvs_pkg
`default_nettype wire

// file: hw/apvs_status.sv
`default_nettype none
module apvs_status (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire apvs_pkg::apvs_exc_state_t exc_state_i,
	input wire logic [63:0][2:0] exc_priority_i,
	output apvs_pkg::apvs_status_t status_o
);
	import apvs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Effective priority, lower wins; NMI and hard fault are fixed
	function automatic logic [3:0] apvs_eff_prio(input logic [5:0] code,
			input logic [2:0] level);
		logic [3:0] p;
		p = {1'b0, level} + PRIO_OFFSET;
		if (code == EXC_NMI) begin
			p = PRIO_NMI;
		end else if (code == EXC_HARD_FAULT) begin
			p = PRIO_HARD_FAULT;
		end
		return p;
	endfunction : apvs_eff_prio

	// Winner of a request vector; ties go to the lower number
	function automatic logic [5:0] apvs_best(input logic [63:0] req,
			input logic [63:0][2:0] pr);
		logic [5:0] num;
		logic [3:0] best;
		logic [3:0] cur;
		logic found;
		num = EXC_NONE;
		best = PRIO_LOWEST;
		found = 1'b0;
		for (int i = 0; i < 64; i++) begin
			cur = apvs_eff_prio(6'(i), pr[i]);
			if (req[i] && (!found || cur < best)) begin
				num = 6'(i);
				best = cur;
				found = 1'b1;
			end
		end
		return num;
	endfunction : apvs_best

	// True when some request beats the given code
	function automatic logic apvs_beaten(input logic [63:0] req,
			input logic [63:0][2:0] pr, input logic [5:0] code);
		logic hit;
		logic [3:0] ref_p;
		hit = 1'b0;
		ref_p = apvs_eff_prio(code, pr[code]);
		for (int i = 0; i < 64; i++) begin
			if (req[i] && apvs_eff_prio(6'(i), pr[i]) < ref_p) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : apvs_beaten

	////////////////////////////////////////////////////////////////////////
	// Decode

	// Reserved codes are masked, so 0x3C-0x3F can never win
	logic [63:0] pend_req_w;
	logic [5:0] pend_num_w;
	logic [63:0] flag_act_w;
	logic [63:0] cur_bit_w;
	logic others_active_w;
	logic [5:0] act_num_w;
	assign pend_req_w = exc_state_i.pending & exc_state_i.enabled & LEGAL_MASK;
	assign pend_num_w = apvs_best(pend_req_w, exc_priority_i);
	// Running handler's own bit is not a preempted one
	assign cur_bit_w = 64'h0000_0000_0000_0001 << exc_state_i.handler_number_field;
	assign flag_act_w = exc_state_i.active & FLAG_MASK;
	assign others_active_w = |(flag_act_w & ~cur_bit_w);
	assign act_num_w = exc_state_i.handler_number_field;

	////////////////////////////////////////////////////////////////////////
	// Status register

	// No write path exists; the word is refreshed every cycle
	apvs_status_t status_d;
	apvs_status_t status_q;
	always_comb begin
		status_d.pending_exception_number = pend_num_w;
		status_d.only_active_handler_flag = !others_active_w;
		status_d.reserved = RSVD_VALUE;
		status_d.active_exception_number = act_num_w;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			status_q.pending_exception_number <= PEND_RESET;
			status_q.only_active_handler_flag <= FLAG_RESET;
			status_q.reserved <= RSVD_VALUE;
			status_q.active_exception_number <= ACT_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	assign status_o = status_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Inputs of the reset cycle never reach the word, so skip one cycle
	// Two stages: the disable term is read with current values, and one
	// stage would open the checks at the first edge, on the reset word
	logic warm_q;
	logic live_q;
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			warm_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			warm_q <= 1'b1;
			live_q <= warm_q;
		end
	end

	logic beaten_w;
	assign beaten_w = apvs_beaten(pend_req_w, exc_priority_i, pend_num_w);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i || !live_q);

	a_pend_is_pending: assert property (
		status_o.pending_exception_number != EXC_NONE |->
		$past(pend_req_w[pend_num_w]) &&
		status_o.pending_exception_number == $past(pend_num_w)
	) else $error("reported pending number was not pending and enabled");

	a_pend_none_zero: assert property (
		$past(pend_req_w) == 64'h0000_0000_0000_0000 |->
		status_o.pending_exception_number == EXC_NONE
	) else $error("pending number nonzero with nothing pending");

	a_pend_is_highest: assert property (
		status_o.pending_exception_number != EXC_NONE |-> !$past(beaten_w)
	) else $error("a higher-priority pending exception was skipped");

	a_tick_code: assert property (
		$past(pend_req_w) == (64'h0000_0000_0000_0001 << EXC_SYSTEM_TICK_TIMER) |->
		status_o.pending_exception_number == EXC_SYSTEM_TICK_TIMER
	) else $error("lone timer pending not reported as its code");

	a_pend_not_rsvd: assert property (
		status_o.pending_exception_number < EXC_RSVD_FIRST
	) else $error("reserved code reported as pending");

	a_flag_low_preempt: assert property (
		$past(|(exc_state_i.active & FLAG_MASK & ~cur_bit_w)) |->
		!status_o.only_active_handler_flag
	) else $error("flag high with preempted interrupts active");

	a_flag_high_alone: assert property (
		$past((exc_state_i.active & FLAG_MASK & ~cur_bit_w) == 64'h0000_0000_0000_0000) |->
		status_o.only_active_handler_flag
	) else $error("flag low with no other interrupt active");

	a_act_tracks_hnum: assert property (
		$changed(exc_state_i.handler_number_field) |=>
		status_o.active_exception_number == $past(exc_state_i.handler_number_field)
	) else $error("active number lags the handler number field");

	a_act_thread_zero: assert property (
		$past(exc_state_i.handler_number_field) == EXC_NONE |->
		status_o.active_exception_number == EXC_NONE
	) else $error("active number nonzero in thread mode");

	a_rsvd_reads_zero: assert property (
		status_o.reserved == RSVD_VALUE
	) else $error("reserved bits not zero");

	// Any nonzero reported code must be one that names a real exception
	a_pend_code_legal: assert property (
		status_o.pending_exception_number == EXC_NONE ||
		LEGAL_MASK[status_o.pending_exception_number]
	) else $error("pending number is not a legal exception code");

	// Lone-code checks pin down the ends of the encoding table
	a_deferred_call_code: assert property (
		$past(pend_req_w) == (64'h0000_0000_0000_0001 << EXC_DEFERRED_SERVICE_CALL) |->
		status_o.pending_exception_number == EXC_DEFERRED_SERVICE_CALL
	) else $error("lone deferred call not reported as its code");

	a_irq_first_code: assert property (
		$past(pend_req_w) == (64'h0000_0000_0000_0001 << EXC_FIRST_IRQ) |->
		status_o.pending_exception_number == EXC_FIRST_IRQ
	) else $error("lone first vector not reported as its code");

	a_irq_last_code: assert property (
		$past(pend_req_w) == (64'h0000_0000_0000_0001 << EXC_LAST_IRQ) |->
		status_o.pending_exception_number == EXC_LAST_IRQ
	) else $error("lone last vector not reported as its code");

	a_flag_none_active: assert property (
		$past(exc_state_i.active & FLAG_MASK) == 64'h0000_0000_0000_0000 |->
		status_o.only_active_handler_flag
	) else $error("flag low with nothing active");

	// Checked every cycle, not only on a change, so a stuck copy shows up
	a_act_each_cycle: assert property (
		status_o.active_exception_number ==
		$past(exc_state_i.handler_number_field)
	) else $error("active number differs from the handler number field");
endmodule : apvs_status
`default_nettype wire

// file: verification/apvs_core_model.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Core side: the running handler is marked active with the preempted ones whenever the handler number is nonzero
module apvs_core_model
	import apvs_pkg::*;
(
	input wire logic [63:0] pend_i,
	input wire logic [63:0] en_i,
	input wire logic [63:0] preempted_i,
	input wire logic [5:0] hnum_i,
	output apvs_pkg::apvs_exc_state_t state_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Thread mode has no own active bit, so nothing to add
	assign state_o.pending = pend_i;
	assign state_o.enabled = en_i;
	assign state_o.active = preempted_i | ((hnum_i != 6'h00) ? (64'h1 << hnum_i) : 64'h0);
	assign state_o.handler_number_field = hnum_i;
endmodule : apvs_core_model
`default_nettype wire

// file: verification/tb_active_pending_vector_status.sv
`default_nettype none
module tb_active_pending_vector_status;
	timeunit 1ns;
	timeprecision 1ps;
	import apvs_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [63:0] pend = '0;
	logic [63:0] en = '0;
	logic [63:0] pre = '0;
	logic [5:0] hnum = 6'h00;
	logic [63:0][2:0] prio = '0;
	apvs_exc_state_t st;
	apvs_status_t status;
	int err_count = 0;
	int num_checks = 0;
	logic [5:0] codes [4] = '{6'h0E, 6'h0F, 6'h10, 6'h3B};
	always #2.5 ref_clk_i = ~ref_clk_i;
	apvs_core_model u_core (.pend_i(pend), .en_i(en), .preempted_i(pre), .hnum_i(hnum),
		.state_o(st));
	apvs_status u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .exc_state_i(st),
		.exc_priority_i(prio), .status_o(status));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Two edges: the word samples and lands on the first, the second is margin
	task automatic settle();
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : settle
	function automatic logic [17:0] word(input logic [5:0] p, input logic f, input logic [5:0] a);
		return {p, f, RSVD_VALUE, a};
	endfunction : word
	task automatic test_encoding();
		en = '1;
		foreach (codes[i]) begin
			pend = 64'h1 << codes[i];
			settle();
			chk(status, word(codes[i], 1'b1, 6'h00));
		end
		pend = 64'hF000_0000_0000_0000;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h00));
		pend = 64'h1 << 16;
		en = '0;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h00));
		$display("test encoding done");
	endtask : test_encoding
	task automatic test_priority();
		en = '1;
		pend = (64'h1 << 16) | (64'h1 << 32);
		prio[16] = 3'h3;
		settle();
		chk(status, word(6'h20, 1'b1, 6'h00));
		chk(18'(status.pending_exception_number - 6'(IRQ_BASE)), 18'h0_0010);
		prio[16] = 3'h0;
		settle();
		chk(status, word(6'h10, 1'b1, 6'h00));
		pend = pend | (64'h1 << 2);
		settle();
		chk(status, word(6'h02, 1'b1, 6'h00));
		pend = '0;
		$display("test priority done");
	endtask : test_priority
	task automatic test_flag();
		hnum = 6'h10;
		pre = 64'h1 << 20;
		settle();
		chk(status, word(6'h00, 1'b0, 6'h10));
		pre = (64'h1 << 2) | (64'h1 << 3);
		settle();
		chk(status, word(6'h00, 1'b1, 6'h10));
		pre = '0;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h10));
		hnum = 6'h00;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h00));
		$display("test flag done");
	endtask : test_flag
	// Reset in mid-run: the word drops to its reset value and recovers
	task automatic test_mid_reset();
		en = '1;
		pend = 64'h1 << EXC_SYSTEM_TICK_TIMER;
		hnum = 6'h10;
		pre = 64'h1 << 20;
		settle();
		chk(status, word(6'h0F, 1'b0, 6'h10));
		sys_rst_i = 1'b1;
		settle();
		chk(status, word(PEND_RESET, FLAG_RESET, ACT_RESET));
		sys_rst_i = 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk(status, word(6'h0F, 1'b0, 6'h10));
		pend = '0;
		en = '0;
		pre = '0;
		hnum = 6'h00;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h00));
		$display("test mid reset done");
	endtask : test_mid_reset
	task automatic complete_run();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	// Watchdog: the whole sequence needs well under a microsecond
	initial begin
		#5000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge ref_clk_i);
		#1;
		chk(status, '0);
		sys_rst_i = 1'b0;
		settle();
		chk(status, word(6'h00, 1'b1, 6'h00));
		test_encoding();
		test_priority();
		test_flag();
		test_mid_reset();
		complete_run();
	end
endmodule : tb_active_pending_vector_status
`default_nettype wire
